// [bench/cala_dmem_model.sv]
// Data memory model that answers the read requests of the 8-bit slice
`timescale 1ns/100ps
module cala_dmem_model #(
    parameter int DM_ADDR_W = 9
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Read request from the slice
    input  wire logic                 dm_rd_r,
    input  wire logic [DM_ADDR_W-1:0] dm_addr_r,
    input  wire logic                 idx_upd_r,
    // Answer to the slice
    output logic [7:0]                dm_rdata,
    output logic [15:0]               idx_cnt
);
    // ********************************************************
    // Read path
    // ********************************************************
    // read at address
    // Toggles between reads so data sampled one cycle late never match
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            dm_rdata <= 8'h00;
        else if (dm_rd_r)
            dm_rdata <= dm_addr_r[7:0] * 8'h25 + 8'h0B;
        else
            dm_rdata <= ~dm_rdata;
    end

    // index with read
    // Counts index updates paired with a read
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            idx_cnt <= 16'h0000;
        else
            idx_cnt <= idx_cnt + 16'(idx_upd_r & dm_rd_r);
    end
endmodule

// [bench/testbench.sv]
// Self-checking testbench of the 8-bit logic and arithmetic slice
`timescale 1ns/100ps
module testbench;
    import cala_pkg::*;
    logic             core_clk, arst_n, op_start, sw_wr, sw_rd;
    cala_kind_t       op_kind, rk;
    cala_form_t       op_form, rf;
    logic [3:0]       op_dst, rf_waddr_r;
    logic [7:0]       reg1_val, reg2_val, reg3_val, imm_val, dm_rdata, sw_wdata, sw_rdata_r;
    logic [8:0]       mem_addr, dm_addr_r;
    logic             dm_rd_r, idx_upd_r, busy_r, done_r, rf_we_r, carry_r, ovf_r, zero_r;
    logic [7:0]       rf_wdata_r, result_copy_r;
    logic [1:0]       sw_addr;
    logic [15:0]      idx_cnt;
    logic [31:0]      lfsr_s;
    int               fail_count, compares, cycles, nmem;

    // ********************************************************
    // Clock, design, memory model
    // ********************************************************
    // Clock of 100 MHz
    always #5 core_clk = ~core_clk;

    cala_core #(.DM_ADDR_W(9), .REG_IDX_W(4)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .op_start(op_start), .op_kind(op_kind), .op_form(op_form), .op_dst(op_dst),
        .reg1_val(reg1_val), .reg2_val(reg2_val), .reg3_val(reg3_val), .imm_val(imm_val),
        .mem_addr(mem_addr), .dm_rd_r(dm_rd_r), .dm_addr_r(dm_addr_r), .dm_rdata(dm_rdata),
        .idx_upd_r(idx_upd_r), .busy_r(busy_r), .done_r(done_r), .rf_we_r(rf_we_r),
        .rf_waddr_r(rf_waddr_r), .rf_wdata_r(rf_wdata_r), .result_copy_r(result_copy_r),
        .carry_r(carry_r), .ovf_r(ovf_r), .zero_r(zero_r), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r));

    cala_dmem_model #(.DM_ADDR_W(9)) dmem (.core_clk(core_clk), .arst_n(arst_n), .dm_rd_r(dm_rd_r),
        .dm_addr_r(dm_addr_r), .idx_upd_r(idx_upd_r), .dm_rdata(dm_rdata), .idx_cnt(idx_cnt));

    // ********************************************************
    // Helpers and expectations
    // ********************************************************
    // Fixed-seed shift register keeps every run identical
    function automatic logic [31:0] rnd();
        lfsr_s = {lfsr_s[30:0], ^(lfsr_s & 32'h80200003)};
        return lfsr_s;
    endfunction

    function automatic logic legal(input cala_kind_t k, input cala_form_t f);
        if (k == K_DEC || k == K_DECC)
            return f == F_ONE || f == F_TWO || f == F_MEM;
        return f != F_ONE;
    endfunction

    // Expected {z, v, c, res}; logic kinds keep c and v
    function automatic logic [10:0] exp_op(input cala_kind_t k, input cala_form_t f, input logic [2:0] fl,
                                           input logic [7:0] r1, r2, r3, imm, dm);
        logic [7:0] x, y, a, b, r;
        logic [8:0] s;
        logic       c, v, bw;
        x = (f == F_THREE) ? r2 : r1;
        y = (f == F_IMM) ? imm : (f == F_TWO) ? r2 : (f == F_THREE) ? r3 : dm;
        c = fl[0];
        v = fl[1];
        a = x;
        b = y;
        bw = (k == K_DECC || k == K_SUBRC || k == K_SUBFC) ? ~c : 1'b0;
        if (k == K_DEC || k == K_DECC)
        begin
            a = (f == F_ONE) ? r1 : y;
            b = (k == K_DEC) ? 8'h01 : 8'h00;
        end
        if (((k == K_SUBR || k == K_SUBRC) && f != F_THREE) || ((k == K_SUBF || k == K_SUBFC) && f == F_THREE))
        begin
            a = y;
            b = x;
        end
        if (k == K_AND || k == K_OR || k == K_XOR)
            r = (k == K_AND) ? (x & y) : (k == K_OR) ? (x | y) : (x ^ y);
        else if (k == K_ADD || k == K_ADDC)
        begin
            s = {1'b0, x} + {1'b0, y} + 9'((k == K_ADDC) & c);
            r = s[7:0];
            c = s[8];
            v = (x[7] == y[7]) && (r[7] != x[7]);
        end
        else
        begin
            s = {1'b0, a} - {1'b0, b} - 9'(bw);
            r = s[7:0];
            c = ~s[8];
            v = (a[7] != b[7]) && (r[7] != a[7]);
        end
        return {r == 8'h00, v, c, r};
    endfunction

    task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string w);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t: %s got %h want %h", $time, w, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e, input string w);
        chk_val(16'(g), 16'(e), w);
    endtask

    // ********************************************************
    // Bus and operation tasks
    // ********************************************************
    task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask

    // Read data stand in the next cycle only, zero after
    task automatic sw_read(input logic [1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1 chk_val(16'(sw_rdata_r), 16'(e), "read data");
        @(posedge core_clk);
        #1 chk_val(16'(sw_rdata_r), 16'h0000, "read idle");
    endtask

    // Operands flip after the take edge so a live path shows up
    task automatic do_op(input cala_kind_t k, input cala_form_t f, input logic [2:0] fl,
                         input logic [7:0] r1, r2, r3, imm, input logic [8:0] ma, input logic hold);
        logic [10:0] e;
        logic [3:0]  d;
        logic        rd;
        int          n;
        e = exp_op(k, f, fl, r1, r2, r3, imm, ma[7:0] * 8'h25 + 8'h0B);
        d = 4'(rnd());
        rd = 1'b0;
        sw_write(ADR_FLAGS, {5'h00, fl});
        @(posedge core_clk);
        {op_start, op_kind, op_form, op_dst, mem_addr} <= {1'b1, k, f, d, ma};
        {reg1_val, reg2_val, reg3_val, imm_val} <= {r1, r2, r3, imm};
        for (n = 1; n < 9; n++)
        begin
            @(posedge core_clk);
            op_start <= hold && n == 1;
            {reg1_val, reg2_val, reg3_val, imm_val} <= ~{r1, r2, r3, imm};
            #1;
            if (n == 1)
                chk_flag(busy_r, 1'b1, "busy");
            if (dm_rd_r === 1'b1)
            begin
                rd = 1'b1;
                chk_val(16'(dm_addr_r), 16'(ma), "memory address");
            end
            if (done_r === 1'b1)
                break;
        end
        chk_val(16'(n), (f == F_MEM) ? 16'h0004 : 16'h0002, "latency");
        chk_flag(rd, f == F_MEM, "memory read");
        chk_flag(rf_we_r, 1'b1, "write enable");
        chk_val(16'(rf_waddr_r), 16'(d), "write index");
        chk_val(16'(rf_wdata_r), 16'(e[7:0]), "result");
        chk_val(16'(result_copy_r), 16'(e[7:0]), "copy");
        chk_val(16'({zero_r, ovf_r, carry_r}), 16'(e[10:8]), "flags");
        sw_read(ADR_FLAGS, {5'h00, e[10:8]});
        sw_read(ADR_COPY, e[7:0]);
    endtask

    // Illegal kind and form pairs are ignored silently
    task automatic try_bad(input cala_kind_t k, input cala_form_t f);
        logic seen;
        seen = 1'b0;
        @(posedge core_clk);
        {op_start, op_kind, op_form} <= {1'b1, k, f};
        @(posedge core_clk);
        op_start <= 1'b0;
        repeat (6)
        begin
            @(posedge core_clk);
            #1 seen = seen | (done_r !== 1'b0) | (busy_r !== 1'b0);
        end
        chk_flag(seen, 1'b0, "refused pair");
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        {core_clk, arst_n, op_start, sw_wr, sw_rd, op_dst, mem_addr, sw_addr, sw_wdata} = '0;
        {reg1_val, reg2_val, reg3_val, imm_val} = '0;
        op_kind = K_DEC;
        op_form = F_ONE;
        lfsr_s = 32'h44802b4a;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, read-only and unmapped places
        sw_read(ADR_FLAGS, 8'h00);
        sw_read(ADR_COPY, 8'h00);
        sw_read(2'h2, 8'h00);
        sw_read(2'h3, 8'h00);
        sw_write(ADR_FLAGS, 8'hFF);
        sw_read(ADR_FLAGS, 8'h07);
        sw_write(ADR_COPY, 8'h5A);
        sw_read(ADR_COPY, 8'h00);
        $display("test registers done");
        // Every kind against every form
        for (int k = 0; k < 11; k++)
            for (int f = 0; f < 5; f++)
                if (legal(cala_kind_t'(4'(k)), cala_form_t'(3'(f))))
                    do_op(cala_kind_t'(4'(k)), cala_form_t'(3'(f)), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), 1'b0);
                else
                    try_bad(cala_kind_t'(4'(k)), cala_form_t'(3'(f)));
        $display("test kinds done");
        // Boundary cases
        do_op(K_DEC, F_ONE, 3'h7, 8'h00, 8'h11, 8'h22, 8'h33, 9'h000, 1'b0);
        do_op(K_DEC, F_MEM, 3'h0, 8'h80, 8'h11, 8'h22, 8'h33, 9'h091, 1'b0);
        do_op(K_DECC, F_TWO, 3'h0, 8'h55, 8'h00, 8'h22, 8'h33, 9'h000, 1'b0);
        do_op(K_DECC, F_ONE, 3'h1, 8'h00, 8'h01, 8'h22, 8'h33, 9'h000, 1'b0);
        do_op(K_DECC, F_MEM, 3'h0, 8'h12, 8'h01, 8'h22, 8'h33, 9'h091, 1'b0);
        do_op(K_ADD, F_IMM, 3'h0, 8'hFF, 8'h01, 8'h22, 8'h01, 9'h000, 1'b0);
        do_op(K_ADDC, F_TWO, 3'h1, 8'h7F, 8'h00, 8'h22, 8'h33, 9'h000, 1'b0);
        do_op(K_SUBRC, F_IMM, 3'h0, 8'h00, 8'h11, 8'h22, 8'h00, 9'h000, 1'b0);
        do_op(K_SUBF, F_THREE, 3'h3, 8'h44, 8'h01, 8'h00, 8'h33, 9'h000, 1'b0);
        do_op(K_SUBFC, F_THREE, 3'h0, 8'h44, 8'h00, 8'h01, 8'h33, 9'h000, 1'b0);
        do_op(K_XOR, F_MEM, 3'h3, 8'h0B, 8'h11, 8'h22, 8'h33, 9'h100, 1'b0);
        do_op(K_ADD, F_TWO, 3'h0, 8'h21, 8'h43, 8'h22, 8'h33, 9'h000, 1'b1);
        $display("test corners done");
        // Random traffic
        nmem = idx_cnt;
        repeat (150)
        begin
            rk = cala_kind_t'(4'(rnd() % 11));
            rf = cala_form_t'(3'(rnd() % 5));
            if (!legal(rk, rf))
                rf = F_TWO;
            if (rf == F_MEM)
                nmem++;
            do_op(rk, rf, rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), 1'b0);
        end
        chk_val(idx_cnt, 16'(nmem), "index updates");
        $display("test random done");
        test_done();
    end
endmodule

// [core/cala_arith.sv]
// Combinational 8-bit adder, subtractor and logic unit with flag logic
`timescale 1ns/100ps
module cala_arith
(
    // Operation and operands
    input  cala_pkg::cala_kind_t kind,
    input  logic [7:0]           opnd_m,
    input  logic [7:0]           opnd_s,
    input  logic                 carry_in,
    input  logic                 ovf_in,
    // Result and flags
    output logic [7:0]           res,
    output logic                 carry_out,
    output logic                 ovf_out,
    output logic                 zero_out
);
    import cala_pkg::*;

    logic [8:0] wide;
    logic       borrow_in;

    // Carry is "no borrow" for the subtract group, a decrement is m - 0 - borrow
    always_comb
    begin
        wide      = 9'h000;
        borrow_in = 1'b0;
        carry_out = carry_in;
        ovf_out   = ovf_in;
        unique case (kind)
            K_DEC, K_DECC, K_SUBR, K_SUBRC, K_SUBF, K_SUBFC:
            begin
                borrow_in = (kind == K_DEC) ? 1'b1 :
                            ((kind == K_SUBR) || (kind == K_SUBF)) ? 1'b0 : ~carry_in;
                wide      = {1'b0, opnd_m} - {1'b0, opnd_s} - {8'h00, borrow_in};
                carry_out = ~wide[8];
                ovf_out   = (opnd_m[7] ^ opnd_s[7]) & (wide[7] ^ opnd_m[7]);
            end
            K_ADD, K_ADDC:
            begin
                wide      = {1'b0, opnd_m} + {1'b0, opnd_s} + {8'h00, (kind == K_ADDC) & carry_in};
                carry_out = wide[8];
                ovf_out   = ~(opnd_m[7] ^ opnd_s[7]) & (wide[7] ^ opnd_m[7]);
            end
            K_AND: wide = {1'b0, opnd_m & opnd_s};
            K_OR:  wide = {1'b0, opnd_m | opnd_s};
            K_XOR: wide = {1'b0, opnd_m ^ opnd_s};
            default: wide = 9'h000;
        endcase
    end

    assign res      = wide[7:0];
    assign zero_out = (wide[7:0] == 8'h00);

endmodule

// [core/cala_core.sv]
// Operation sequencer, flag register and result copy of the 8-bit ALU slice
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Register decrement, carry clear on hFF
// - Memory decrement writes register and copy
// - Decrement with borrow, carry rule kept
// - Memory decrement with borrow exists too
// - AND updates zero, keeps carry, overflow
// - OR updates zero only
// - XOR updates zero only
// - Three-register uses second, third; writes first
// - Add sets carry past eight bits
// - Add with carry includes incoming carry
// - Reverse subtract immediate minus register
// - Two-register reverse is second minus first
// - Reverse with borrow subtracts one minus carry
// - Forward subtract register minus immediate
// - Three-register forward is third minus second
// - Memory forward is register minus memory
// - Forward with borrow subtracts one minus carry
// - Three-register forward borrow: third minus second
// - Dash keeps flag; u means undefined
// - Memory access and index update together
module cala_core #(
    parameter int DM_ADDR_W = 9,
    parameter int REG_IDX_W = 4
) (
    // Clock and reset
    input  logic                             core_clk,
    input  logic                             arst_n,
    // Operation request
    input  logic                             op_start,
    input  cala_pkg::cala_kind_t             op_kind,
    input  cala_pkg::cala_form_t             op_form,
    input  logic [REG_IDX_W-1:0]             op_dst,
    // Operand values
    input  logic [7:0]                       reg1_val,
    input  logic [7:0]                       reg2_val,
    input  logic [7:0]                       reg3_val,
    input  logic [7:0]                       imm_val,
    input  logic [DM_ADDR_W-1:0]             mem_addr,
    // Data memory
    output logic                             dm_rd_r,
    output logic [DM_ADDR_W-1:0]             dm_addr_r,
    input  logic [7:0]                       dm_rdata,
    output logic                             idx_upd_r,
    // Results
    output logic                             busy_r,
    output logic                             done_r,
    output logic                             rf_we_r,
    output logic [REG_IDX_W-1:0]             rf_waddr_r,
    output logic [7:0]                       rf_wdata_r,
    output logic [7:0]                       result_copy_r,
    output logic                             carry_r,
    output logic                             ovf_r,
    output logic                             zero_r,
    // Software port
    input  logic [cala_pkg::SW_ADDR_W-1:0]   sw_addr,
    input  logic [7:0]                       sw_wdata,
    input  logic                             sw_wr,
    input  logic                             sw_rd,
    output logic [7:0]                       sw_rdata_r
);
    import cala_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (DM_ADDR_W < 8 || DM_ADDR_W > 16)
    begin : g_bad_addr
        $error("DM_ADDR_W must lie in 8..16");
    end
    if (REG_IDX_W < 1 || REG_IDX_W > 8)
    begin : g_bad_idx
        $error("REG_IDX_W must lie in 1..8");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic is_dec(input cala_kind_t k);
        is_dec = (k == K_DEC) || (k == K_DECC);
    endfunction

    function automatic logic is_logic(input cala_kind_t k);
        is_logic = (k == K_AND) || (k == K_OR) || (k == K_XOR);
    endfunction

    // Decrements take one source only; the rest take two
    function automatic logic is_legal(input cala_kind_t k, input cala_form_t f);
        if (is_dec(k))
            is_legal = (f == F_ONE) || (f == F_TWO) || (f == F_MEM);
        else
            is_legal = (k <= K_SUBFC) && ((f == F_IMM) || (f == F_TWO) ||
                                          (f == F_THREE) || (f == F_MEM));
    endfunction

    // ****************************************************************
    // Operation latch and sequencing
    // ****************************************************************
    cala_state_t          state_r;
    cala_state_t          state_nxt;
    cala_kind_t           kind_r;
    cala_form_t           form_r;
    logic [REG_IDX_W-1:0] dst_r;
    logic [7:0]           x_r;
    logic [7:0]           y_r;
    logic [7:0]           x_nxt;
    logic [7:0]           y_nxt;
    logic                 take;
    logic                 swap;
    logic [7:0]           alu_m;
    logic [7:0]           alu_s;
    logic [7:0]           alu_res;
    logic                 alu_c;
    logic                 alu_v;
    logic                 alu_z;
    logic                 exec;

    // Requests arriving while busy or with an illegal pairing are dropped
    assign take = op_start && (state_r == S_IDLE) && is_legal(op_kind, op_form);
    assign exec = (state_r == S_EXEC);

    // First and second operand as the form presents them
    always_comb
    begin
        x_nxt = reg1_val;
        y_nxt = BYTE_RST;
        unique case (op_form)
            F_ONE:   x_nxt = reg1_val;
            F_IMM:   y_nxt = imm_val;
            F_TWO:
            begin
                x_nxt = is_dec(op_kind) ? reg2_val : reg1_val;
                y_nxt = is_dec(op_kind) ? BYTE_RST : reg2_val;
            end
            F_THREE:
            begin
                x_nxt = reg2_val;
                y_nxt = reg3_val;
            end
            F_MEM:   x_nxt = reg1_val;
            default: x_nxt = reg1_val;
        endcase
    end

    // Next state of the sequencer
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE:   if (take) state_nxt = (op_form == F_MEM) ? S_MEMRD : S_EXEC;
            S_MEMRD:  state_nxt = S_MEMDAT;
            S_MEMDAT: state_nxt = S_EXEC;
            S_EXEC:   state_nxt = S_IDLE;
        endcase
    end

    // State, busy and the latched operation
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= S_IDLE;
            busy_r  <= 1'b0;
            kind_r  <= K_DEC;
            form_r  <= F_ONE;
            dst_r   <= '0;
            x_r     <= BYTE_RST;
            y_r     <= BYTE_RST;
        end
        else
        begin
            state_r <= state_nxt;
            busy_r  <= (state_nxt != S_IDLE);
            if (take)
            begin
                kind_r <= op_kind;
                form_r <= op_form;
                dst_r  <= op_dst;
                x_r    <= x_nxt;
                y_r    <= y_nxt;
            end
            else if (state_r == S_MEMDAT)
            begin
                if (is_dec(kind_r))
                    x_r <= dm_rdata;
                else
                    y_r <= dm_rdata;
            end
        end
    end

    // ****************************************************************
    // Data memory access
    // ****************************************************************
    // read and index update together
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dm_rd_r   <= 1'b0;
            idx_upd_r <= 1'b0;
            dm_addr_r <= '0;
        end
        else
        begin
            dm_rd_r   <= take && (op_form == F_MEM);
            idx_upd_r <= take && (op_form == F_MEM);
            if (take && (op_form == F_MEM))
                dm_addr_r <= mem_addr;
        end
    end

    // ****************************************************************
    // Arithmetic unit
    // ****************************************************************
    // operand order; three-register flips it
    assign swap  = ((kind_r == K_SUBR) || (kind_r == K_SUBRC)) ^ (form_r == F_THREE)
                   & ((kind_r >= K_SUBR) && (kind_r <= K_SUBFC));
    assign alu_m = swap ? y_r : x_r;
    assign alu_s = swap ? x_r : y_r;

    cala_arith u_arith (
        .kind      (kind_r),
        .opnd_m    (alu_m),
        .opnd_s    (alu_s),
        .carry_in  (carry_r),
        .ovf_in    (ovf_r),
        .res       (alu_res),
        .carry_out (alu_c),
        .ovf_out   (alu_v),
        .zero_out  (alu_z)
    );

    // ****************************************************************
    // Result write and flags
    // ****************************************************************
    // result to register and copy
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_r        <= 1'b0;
            rf_we_r       <= 1'b0;
            rf_waddr_r    <= '0;
            rf_wdata_r    <= BYTE_RST;
            result_copy_r <= BYTE_RST;
        end
        else
        begin
            done_r  <= exec;
            rf_we_r <= exec;
            if (exec)
            begin
                rf_waddr_r    <= dst_r;
                rf_wdata_r    <= alu_res;
                result_copy_r <= alu_res;
            end
        end
    end

    // Operation update wins over a software write in the same cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            carry_r <= FLAG_RST;
            ovf_r   <= FLAG_RST;
            zero_r  <= FLAG_RST;
        end
        else if (exec)
        begin
            carry_r <= alu_c;
            ovf_r   <= alu_v;
            zero_r  <= alu_z;
        end
        else if (sw_wr && (sw_addr == ADR_FLAGS))
        begin
            carry_r <= sw_wdata[FLG_C];
            ovf_r   <= sw_wdata[FLG_V];
            zero_r  <= sw_wdata[FLG_Z];
        end
    end

    // ****************************************************************
    // Software read port
    // ****************************************************************
    // Unmapped addresses read zero
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sw_rdata_r <= BYTE_RST;
        else if (sw_rd)
        begin
            sw_rdata_r <= BYTE_RST;
            if (sw_addr == ADR_FLAGS)
            begin
                sw_rdata_r[FLG_C]    <= carry_r;
                sw_rdata_r[FLG_V]    <= ovf_r;
                sw_rdata_r[FLG_Z]    <= zero_r;
                sw_rdata_r[FLG_BUSY] <= busy_r;
            end
            else if (sw_addr == ADR_COPY)
                sw_rdata_r <= result_copy_r;
        end
        else
            sw_rdata_r <= BYTE_RST;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking dflt_cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    chk_dec_carry: assert property (
        done_r && (kind_r == K_DEC) |-> carry_r == (rf_wdata_r != BYTE_FF))
        else $error("decrement carry wrong");

    chk_decc_carry: assert property (
        done_r && (kind_r == K_DECC) |->
        carry_r == !((rf_wdata_r == BYTE_FF) && !$past(carry_r)))
        else $error("decrement with borrow carry wrong");

    chk_logic_keep: assert property (
        done_r && is_logic(kind_r) |->
        (carry_r == $past(carry_r)) && (ovf_r == $past(ovf_r)))
        else $error("logic op changed carry or overflow");

    chk_zero_copy: assert property (
        done_r |-> (zero_r == (rf_wdata_r == 8'h00)) && (result_copy_r == rf_wdata_r))
        else $error("zero flag or result copy wrong");

    chk_add_sum: assert property (
        done_r && (kind_r == K_ADD) |->
        {carry_r, rf_wdata_r} == ({1'b0, $past(alu_m)} + {1'b0, $past(alu_s)}))
        else $error("add sum or carry wrong");

    chk_subc_borrow: assert property (
        done_r && ((kind_r == K_SUBFC) || (kind_r == K_SUBRC)) |->
        carry_r == ({1'b0, $past(alu_m)} >= ({1'b0, $past(alu_s)} + {8'h00, !$past(carry_r)})))
        else $error("subtract with borrow carry wrong");

    chk_sub_order: assert property (
        exec && (kind_r == K_SUBF) && (form_r == F_THREE) |-> (alu_m == y_r) && (alu_s == x_r))
        else $error("three-register forward order wrong");

    chk_mem_seq: assert property (
        dm_rd_r |-> idx_upd_r ##1 !dm_rd_r ##2 (done_r && rf_we_r))
        else $error("memory read sequence wrong");

    chk_reg_latency: assert property (
        take && (op_form != F_MEM) |-> ##2 (done_r && (rf_waddr_r == $past(op_dst, 2))))
        else $error("register form latency or destination wrong");

    cov_mem_xor: cover property (done_r && (kind_r == K_XOR) && (form_r == F_MEM));
    cov_decc_ff: cover property (done_r && (kind_r == K_DECC) && (rf_wdata_r == BYTE_FF));
    cov_addc_c:  cover property (done_r && (kind_r == K_ADDC) && carry_r);
    cov_subr3:   cover property (done_r && (kind_r == K_SUBRC) && (form_r == F_THREE));

endmodule

// [core/cala_pkg.sv]
// Shared constants and types for the 8-bit logic and arithmetic slice
package cala_pkg;

    // ****************************************************************
    // Operation kinds and operand forms
    // ****************************************************************
    localparam int KIND_W = 4;
    localparam int FORM_W = 3;

    typedef enum logic [KIND_W-1:0] {
        K_DEC   = 4'h0,
        K_DECC  = 4'h1,
        K_AND   = 4'h2,
        K_OR    = 4'h3,
        K_XOR   = 4'h4,
        K_ADD   = 4'h5,
        K_ADDC  = 4'h6,
        K_SUBR  = 4'h7,
        K_SUBRC = 4'h8,
        K_SUBF  = 4'h9,
        K_SUBFC = 4'hA
    } cala_kind_t;

    typedef enum logic [FORM_W-1:0] {
        F_ONE   = 3'h0,
        F_IMM   = 3'h1,
        F_TWO   = 3'h2,
        F_THREE = 3'h3,
        F_MEM   = 3'h4
    } cala_form_t;

    typedef enum logic [1:0] {
        S_IDLE   = 2'h0,
        S_MEMRD  = 2'h1,
        S_MEMDAT = 2'h2,
        S_EXEC   = 2'h3
    } cala_state_t;

    // ****************************************************************
    // Software port map, flag layout, reset values
    // ****************************************************************
    localparam int             SW_ADDR_W = 2;
    localparam logic [1:0]     ADR_FLAGS = 2'h0;
    localparam logic [1:0]     ADR_COPY  = 2'h1;
    localparam int             FLG_C     = 0;
    localparam int             FLG_V     = 1;
    localparam int             FLG_Z     = 2;
    localparam int             FLG_BUSY  = 3;
    localparam logic [7:0]     BYTE_RST  = 8'h00;
    localparam logic [7:0]     BYTE_FF   = 8'hFF;
    localparam logic           FLAG_RST  = 1'b0;

endpackage
